// ---- logic/dcrs_defines.svh ----
`ifndef DCRS_DEFINES_SVH
`define DCRS_DEFINES_SVH
`define DCRS_CODE_W 6
`define DCRS_NOT_SUPPORTED 6'h3f
`define DCRS_SYNC_IDLE 2'b11
`endif

// ---- logic/dcrs_pkg.sv ----
package dcrs_pkg;
	typedef enum logic [2:0]
	{
		DCRS_FULL = 3'b001,
		DCRS_HALF = 3'b010,
		DCRS_QUARTER = 3'b100
	} dcrs_mode_type;
endpackage : dcrs_pkg

// ---- logic/dcrs_ratio_switch.sv ----
`timescale 1ns/1ns
`include "dcrs_defines.svh"
// Operation
// - divide ratio by two or four live
// - half mode from bit or pin
// - full ratio when half request drops
// - quarter mode from bit or pin
// - ratio change takes one clock from the bits, three from the pins
// - any request pin overrides software bits
// - both pins disable switching entirely
// - divided modes depend on latched strap
// - unsupported target keeps present multiplier
// - unsupported quarter from half stays half
// - readback shows multiplier in effect
// - strap 001110 gives 20x table
// - strap 110110 gives 16x table
// - strap 001010 gives 18x table
// - strap 111110 gives 12.5x table
// - strap 000000 gives 11.5x table
// - strap 010010 gives 21x table
module dcrs_ratio_switch
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// strap and software control
	input wire logic [5:0] ratio_strap,
	input wire logic sw_half_speed_bit,
	input wire logic sw_quarter_speed_bit,
	// board request pins
	input wire logic half_speed_request_n,
	input wire logic quarter_speed_request_n,
	// status
	output logic [5:0] ratio_readback,
	output dcrs_pkg::dcrs_mode_type mode_q
);
	logic [5:0] strap_q;
	logic strap_take_q;
	logic [1:0] req_pin_n;
	logic [1:0] half_sync_q;
	logic [1:0] quarter_sync_q;
	logic want_half_d;
	logic want_quarter_d;
	logic [5:0] half_code;
	logic [5:0] quarter_code;
	dcrs_pkg::dcrs_mode_type mode_d;

	// half-mode code per strap, 3f when unsupported
	function automatic logic [5:0] half_of(input logic [5:0] s);
		case (s)
			6'h28: half_of = 6'h10;
			6'h2c: half_of = 6'h15;
			6'h24: half_of = 6'h35;
			6'h34: half_of = 6'h20;
			6'h14: half_of = 6'h20;
			6'h08: half_of = 6'h35;
			6'h04: half_of = 6'h35;
			6'h30: half_of = 6'h28;
			6'h18: half_of = 6'h28;
			6'h1e: half_of = 6'h1d;
			6'h1c: half_of = 6'h1d;
			6'h2a: half_of = 6'h2c;
			6'h22: half_of = 6'h2c;
			6'h26: half_of = 6'h24;
			6'h00: half_of = 6'h24;
			6'h2e: half_of = 6'h34;
			6'h3e: half_of = 6'h34;
			6'h16: half_of = 6'h14;
			6'h38: half_of = 6'h14;
			6'h32: half_of = 6'h08;
			6'h06: half_of = 6'h04;
			6'h36: half_of = 6'h30;
			6'h02: half_of = 6'h18;
			6'h0a: half_of = 6'h1e;
			6'h0e: half_of = 6'h2a;
			6'h12: half_of = 6'h22;
			default: half_of = `DCRS_NOT_SUPPORTED;
		endcase
	endfunction : half_of

	// quarter-mode code per strap, 3f when unsupported
	function automatic logic [5:0] quarter_of(input logic [5:0] s);
		case (s)
			6'h30: quarter_of = 6'h10;
			6'h1e: quarter_of = 6'h10;
			6'h2a: quarter_of = 6'h15;
			6'h26: quarter_of = 6'h15;
			6'h2e: quarter_of = 6'h20;
			6'h16: quarter_of = 6'h20;
			6'h32: quarter_of = 6'h35;
			6'h06: quarter_of = 6'h35;
			6'h36: quarter_of = 6'h28;
			6'h02: quarter_of = 6'h28;
			6'h0a: quarter_of = 6'h1d;
			6'h0e: quarter_of = 6'h2c;
			6'h12: quarter_of = 6'h2c;
			default: quarter_of = `DCRS_NOT_SUPPORTED;
		endcase
	endfunction : quarter_of

	// strap caught on the first clock after reset release
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			strap_take_q <= 1'b1;
		else
			strap_take_q <= 1'b0;
		if (strap_take_q || sys_rst)
			strap_q <= ratio_strap;
	end

	// request pins gathered so one synchroniser loop serves both
	assign req_pin_n = {quarter_speed_request_n, half_speed_request_n};

	// two-flop synchronisers, idle high; only the second stage feeds logic
	for (genvar p = 0; p < 2; p++)
	begin : g_pin_sync
		logic [1:0] stage_q;
		always_ff @(posedge clock)
		begin
			if (sys_rst)
				stage_q <= `DCRS_SYNC_IDLE;
			else
				stage_q <= {stage_q[0], req_pin_n[p]};
		end
	end

	// synchroniser outputs by pin
	assign half_sync_q = g_pin_sync[0].stage_q;
	assign quarter_sync_q = g_pin_sync[1].stage_q;

	assign half_code = half_of(strap_q);
	assign quarter_code = quarter_of(strap_q);

	// request arbitration: pins override bits, both pins disable
	always_comb
	begin
		if (!half_sync_q[1] && !quarter_sync_q[1])
		begin
			want_half_d = 1'b0;
			want_quarter_d = 1'b0;
		end
		else if (!half_sync_q[1] || !quarter_sync_q[1])
		begin
			want_half_d = !half_sync_q[1];
			want_quarter_d = !quarter_sync_q[1];
		end
		else
		begin
			want_half_d = sw_half_speed_bit;
			want_quarter_d = sw_quarter_speed_bit;
		end
	end

	// target mode, unsupported targets hold present mode
	always_comb
	begin
		mode_d = mode_q;
		if (want_quarter_d)
		begin
			if (quarter_code != `DCRS_NOT_SUPPORTED)
				mode_d = dcrs_pkg::DCRS_QUARTER;
			else if (mode_q == dcrs_pkg::DCRS_QUARTER)
				mode_d = dcrs_pkg::DCRS_QUARTER;
			else if (mode_q == dcrs_pkg::DCRS_HALF)
				mode_d = dcrs_pkg::DCRS_HALF;
			else
				mode_d = dcrs_pkg::DCRS_FULL;
		end
		else if (want_half_d)
		begin
			if (half_code != `DCRS_NOT_SUPPORTED)
				mode_d = dcrs_pkg::DCRS_HALF;
			else
				mode_d = mode_q;
		end
		else
			mode_d = dcrs_pkg::DCRS_FULL;
	end

	// mode register, one clock per change
	always_ff @(posedge clock)
	begin
		if (sys_rst || strap_take_q)
			mode_q <= dcrs_pkg::DCRS_FULL;
		else
			mode_q <= mode_d;
	end

	// readback of the live multiplier code
	always_ff @(posedge clock)
	begin
		if (sys_rst || strap_take_q)
			ratio_readback <= ratio_strap;
		else
		begin
			case (mode_d)
				dcrs_pkg::DCRS_HALF: ratio_readback <= half_code;
				dcrs_pkg::DCRS_QUARTER: ratio_readback <= quarter_code;
				default: ratio_readback <= strap_q;
			endcase
		end
	end

	// both pins held: always full ratio
	a_both_pins_full: assert property (@(posedge clock) disable iff (sys_rst)
		(!half_sync_q[1] && !quarter_sync_q[1] && !strap_take_q) |=> mode_q == dcrs_pkg::DCRS_FULL)
		else $error("both pins asserted but divided mode");
	// readback matches mode
	a_readback_tracks_mode: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(mode_q == dcrs_pkg::DCRS_HALF) |-> ratio_readback == half_code)
		else $error("half readback wrong");
	a_quarter_readback: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(mode_q == dcrs_pkg::DCRS_QUARTER) |-> ratio_readback == quarter_code)
		else $error("quarter readback wrong");
	// never in an unsupported quarter mode
	a_quarter_supported: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_q == dcrs_pkg::DCRS_QUARTER) |-> quarter_code != `DCRS_NOT_SUPPORTED)
		else $error("unsupported quarter mode entered");
	// half stays when quarter unsupported
	a_half_holds: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(mode_q == dcrs_pkg::DCRS_HALF && want_quarter_d && quarter_code == `DCRS_NOT_SUPPORTED)
		|=> mode_q == dcrs_pkg::DCRS_HALF)
		else $error("left half on rejected quarter");
	// software half honoured in one clock
	a_sw_half_fast: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(half_sync_q[1] && quarter_sync_q[1] && sw_half_speed_bit && !sw_quarter_speed_bit
		&& half_code != `DCRS_NOT_SUPPORTED) |=> mode_q == dcrs_pkg::DCRS_HALF)
		else $error("half mode not entered in one clock");
	// no request returns to full
	a_idle_full: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(half_sync_q[1] && quarter_sync_q[1] && !sw_half_speed_bit && !sw_quarter_speed_bit)
		|=> (mode_q == dcrs_pkg::DCRS_FULL && ratio_readback == strap_q))
		else $error("full ratio not restored");
	// pin overrides software
	a_pin_override: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(!half_sync_q[1] && quarter_sync_q[1] && half_code != `DCRS_NOT_SUPPORTED)
		|=> mode_q == dcrs_pkg::DCRS_HALF)
		else $error("half pin not obeyed");

	// pin requests as sampled on the raw pins; they act three edges later
	sequence s_half_pin_only;
		!half_speed_request_n && quarter_speed_request_n && half_code != `DCRS_NOT_SUPPORTED;
	endsequence
	sequence s_quarter_pin_only;
		half_speed_request_n && !quarter_speed_request_n && quarter_code != `DCRS_NOT_SUPPORTED;
	endsequence
	sequence s_both_pins;
		!half_speed_request_n && !quarter_speed_request_n;
	endsequence
	// settled outputs for each mode
	sequence s_in_full;
		mode_q == dcrs_pkg::DCRS_FULL && ratio_readback == strap_q;
	endsequence
	sequence s_in_half;
		mode_q == dcrs_pkg::DCRS_HALF && ratio_readback == half_code;
	endsequence
	sequence s_in_quarter;
		mode_q == dcrs_pkg::DCRS_QUARTER && ratio_readback == quarter_code;
	endsequence
	// half pin alone wins after two sync flops and the mode flop
	a_half_pin_path: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		s_half_pin_only |-> ##3 s_in_half)
		else $error("half pin not honoured after sync");
	// quarter pin alone, whatever software asks
	a_quarter_pin_path: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		s_quarter_pin_only |-> ##3 s_in_quarter)
		else $error("quarter pin not honoured after sync");
	// both pins: switching off, strap ratio
	a_both_pins_path: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		s_both_pins |-> ##3 s_in_full)
		else $error("both pins did not force strap ratio");
	// software quarter honoured in one clock
	a_sw_quarter_fast: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(half_sync_q[1] && quarter_sync_q[1] && sw_quarter_speed_bit
		&& quarter_code != `DCRS_NOT_SUPPORTED) |=> s_in_quarter)
		else $error("quarter mode not entered in one clock");
	// rejected target from full ratio stays at the strap ratio
	a_full_holds: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(mode_q == dcrs_pkg::DCRS_FULL && want_quarter_d && quarter_code == `DCRS_NOT_SUPPORTED)
		|=> s_in_full)
		else $error("left full ratio on rejected quarter");
	// rejected half request leaves the mode alone
	a_half_refused: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(want_half_d && !want_quarter_d && half_code == `DCRS_NOT_SUPPORTED) |=> $stable(mode_q))
		else $error("mode moved on rejected half");
	// never in an unsupported half mode
	a_half_supported: assert property (@(posedge clock) disable iff (sys_rst)
		(mode_q == dcrs_pkg::DCRS_HALF) |-> half_code != `DCRS_NOT_SUPPORTED)
		else $error("unsupported half mode entered");
	// full ratio reads back the strap
	a_full_readback: assert property (@(posedge clock) disable iff (sys_rst || strap_take_q)
		(mode_q == dcrs_pkg::DCRS_FULL) |-> ratio_readback == strap_q)
		else $error("full readback wrong");
	// strap ratio shown right after reset
	a_strap_after_reset: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(strap_take_q) |-> s_in_full)
		else $error("strap ratio not shown after reset");
endmodule : dcrs_ratio_switch

// ---- bench/dcrs_board_model.sv ----
`timescale 1ns/1ns
// board logic that pulls the request pins low on command
module dcrs_board_model
(
	// commands from the bench
	input wire logic half_req,
	input wire logic quarter_req,
	// live multiplier code from the core
	input wire logic [5:0] ratio_readback,
	// request pins, idle high
	output logic half_speed_request_n,
	output logic quarter_speed_request_n,
	// bus side: hold off address acknowledge while the core runs slow
	output logic addr_acknowledge_delay
);
	// pins follow the bench commands, inverted, with no check of support
	assign half_speed_request_n = ~half_req;
	assign quarter_speed_request_n = ~quarter_req;

	// codes of multipliers below 5x leave time for snoop responses
	always_comb
	begin
		case (ratio_readback)
			6'h10, 6'h20, 6'h28, 6'h15, 6'h35, 6'h1d: addr_acknowledge_delay = 1'b1;
			default: addr_acknowledge_delay = 1'b0;
		endcase
	end
endmodule : dcrs_board_model

// ---- bench/dynamic_core_ratio_switch_bench.sv ----
`timescale 1ns/1ns
module dynamic_core_ratio_switch_bench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] ratio_strap = 6'h00;
	logic sw_half_speed_bit = 1'b0;
	logic sw_quarter_speed_bit = 1'b0;
	logic half_req = 1'b0;
	logic quarter_req = 1'b0;
	wire logic half_speed_request_n;
	wire logic quarter_speed_request_n;
	wire logic addr_acknowledge_delay;
	logic [5:0] ratio_readback;
	dcrs_pkg::dcrs_mode_type mode_q;
	int error_cnt = 0;
	int comparisons = 0;
	int cur = 0;
	logic [5:0] s_c, h_c, q_c;
	logic [2:0] m_c;
	// strap, half and quarter codes; 3f marks an unsupported mode; 01 is unlisted
	logic [5:0] strap_t [8] = '{6'h0e, 6'h36, 6'h0a, 6'h3e, 6'h00, 6'h12, 6'h10, 6'h01};
	logic [5:0] half_t [8] = '{6'h2a, 6'h30, 6'h1e, 6'h34, 6'h24, 6'h22, 6'h3f, 6'h3f};
	logic [5:0] quart_t [8] = '{6'h2c, 6'h28, 6'h1d, 6'h3f, 6'h3f, 6'h2c, 6'h3f, 6'h3f};
	// modes below 5x, one bit per mode: bit 0 full, bit 1 half, bit 2 quarter
	logic [2:0] slow_t [8] = '{3'h0, 3'h4, 3'h4, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0};

	dcrs_ratio_switch dut_u (.clock(clock), .sys_rst(sys_rst), .ratio_strap(ratio_strap),
		.sw_half_speed_bit(sw_half_speed_bit), .sw_quarter_speed_bit(sw_quarter_speed_bit),
		.half_speed_request_n(half_speed_request_n), .quarter_speed_request_n(quarter_speed_request_n),
		.ratio_readback(ratio_readback), .mode_q(mode_q));
	dcrs_board_model board_u (.half_req(half_req), .quarter_req(quarter_req), .ratio_readback(ratio_readback),
		.half_speed_request_n(half_speed_request_n), .quarter_speed_request_n(quarter_speed_request_n),
		.addr_acknowledge_delay(addr_acknowledge_delay));

	// 25 MHz clock
	initial
		forever #20 clock = ~clock;

	// readback code for a mode: 0 full, 1 half, 2 quarter
	function automatic logic [5:0] code_of(input int m);
		return m == 2 ? q_c : (m == 1 ? h_c : s_c);
	endfunction : code_of

	// unsupported target keeps the present mode
	function automatic int pick(input int want);
		return (code_of(want) === 6'h3f) ? cur : want;
	endfunction : pick

	task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// drive requests, wait the settled latency, compare
	task automatic apply(input logic h, input logic q, input logic hp, input logic qp, input int waits);
		@(posedge clock);
		sw_half_speed_bit <= h;
		sw_quarter_speed_bit <= q;
		half_req <= hp;
		quarter_req <= qp;
		repeat (waits) @(posedge clock);
		#1;
		if (hp && qp)
			cur = 0;
		else if (hp || qp)
			cur = pick(qp ? 2 : 1);
		else
			cur = pick(q ? 2 : (h ? 1 : 0));
		check("ratio_readback", ratio_readback, code_of(cur));
		check("mode_q", 6'(mode_q), 6'(1 << cur));
		check("addr_acknowledge_delay", 6'(addr_acknowledge_delay), 6'(m_c[cur]));
	endtask : apply

	// one strap: reset, corner sequence, random software traffic
	task automatic run_strap(input int i);
		s_c = strap_t[i];
		h_c = half_t[i];
		q_c = quart_t[i];
		m_c = slow_t[i];
		@(posedge clock);
		sys_rst <= 1'b1;
		ratio_strap <= s_c;
		sw_half_speed_bit <= 1'b0;
		sw_quarter_speed_bit <= 1'b0;
		half_req <= 1'b0;
		quarter_req <= 1'b0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		cur = 0;
		check("ratio_readback", ratio_readback, s_c);
		check("mode_q", 6'(mode_q), 6'h01);
		check("addr_acknowledge_delay", 6'(addr_acknowledge_delay), 6'(m_c[0]));
		apply(1'b0, 1'b1, 1'b0, 1'b0, 1);
		apply(1'b1, 1'b0, 1'b0, 1'b0, 1);
		apply(1'b0, 1'b1, 1'b0, 1'b0, 1);
		apply(1'b0, 1'b1, 1'b1, 1'b0, 3);
		apply(1'b0, 1'b1, 1'b1, 1'b1, 3);
		apply(1'b0, 1'b1, 1'b0, 1'b0, 3);
		apply(1'b0, 1'b0, 1'b0, 1'b0, 1);
		apply(1'b1, 1'b0, 1'b0, 1'b0, 1);
		apply(1'b1, 1'b0, 1'b0, 1'b1, 3);
		apply(1'b0, 1'b0, 1'b0, 1'b0, 3);
		repeat (24)
			apply(1'($urandom), 1'($urandom), 1'b0, 1'b0, 1);
		$display("strap %b done", s_c);
	endtask : run_strap

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	// main sequence
	initial
	begin
		void'($urandom(32'h8f00));
		for (int i = 0; i < 8; i++)
			run_strap(i);
		final_report();
	end

	// hang guard
	initial
	begin
		#2000000;
		error_cnt++;
		final_report();
	end
endmodule : dynamic_core_ratio_switch_bench
